// [hdl/io_status_word_and_maintenance_counters.sv]
// status word packer, hour counters and hourly peak capture
module io_status_word_and_maintenance_counters (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire io_status_pkg::term_in_t term_in_i,
  input wire io_status_pkg::term_out_t term_out_i,
  input wire io_status_pkg::term_in_t link_in_i,
  input wire logic link_forward_command_i,
  input wire logic link_backward_command_i,
  input wire logic link_reset_command_i,
  input wire logic link_command_word_setting_i,
  input wire logic motor_running_i,
  input wire logic cap_under_voltage_i,
  input wire logic [7:0] env_coeff_i,
  input wire io_status_pkg::peaks_t sample_i,
  input wire logic [15:0] bus_cap_now_i,
  input wire logic [15:0] bus_cap_ship_i,
  input wire logic hour_tick_i,
  input wire logic key_up_i,
  input wire logic key_down_i,
  input wire logic key_prog_i,
  input wire logic key_reset_i,
  output logic [15:0] terminal_input_word_o,
  output logic [15:0] terminal_output_word_o,
  output logic [15:0] link_input_word_o,
  output logic [9:0] link_segments_o,
  output logic link_hex_view_o,
  output logic [15:0] power_on_hours_o,
  output logic [15:0] motor_run_hours_o,
  output logic [15:0] board_electrolytic_hours_o,
  output io_status_pkg::peaks_t hourly_peaks_o,
  output logic [7:0] bus_cond_health_pct_o,
  output io_status_pkg::kp_mode_t kp_mode_o,
  output logic [2:0] io_page_o
);
  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  logic rst_m_q;
  logic rst_b_q;
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_m_q <= 1'b0;
      rst_b_q <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_b_q <= rst_m_q;
    end
  end

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  // terminal pins are asynchronous; the link and keys come from logic
  localparam int SYNC_W = 12;
  logic [SYNC_W-1:0] sync_m_q;
  logic [SYNC_W-1:0] sync_q;
  always_ff @(posedge ref_clk_i or negedge rst_b_q) begin
    if (!rst_b_q) begin
      sync_m_q <= '0;
      sync_q <= '0;
    end else begin
      sync_m_q <= {term_in_i, term_out_i};
      sync_q <= sync_m_q;
    end
  end
  io_status_pkg::term_in_t tin;
  io_status_pkg::term_out_t tout;
  assign tin = sync_q[11:5];
  assign tout = sync_q[4:0];

  // ---------------------------------------------------------------
  // word packing
  // ---------------------------------------------------------------
  function automatic logic [15:0] pack_in(io_status_pkg::term_in_t s);
    logic [15:0] w;
    w = io_status_pkg::WORD_RST; // unmapped bits zero
    w[io_status_pkg::BIT_FWD] = s.forward_run_input;
    w[io_status_pkg::BIT_BWD] = s.bwd;
    for (int i = 0; i < io_status_pkg::GEN_N; i++) begin
      w[io_status_pkg::BIT_GEN0 + i] = s.gen[i];
    end
    return w;
  endfunction

  logic [15:0] out_w;
  always_comb begin
    out_w = io_status_pkg::WORD_RST;
    for (int i = 0; i < io_status_pkg::TR_N; i++) begin
      out_w[io_status_pkg::BIT_TR0 + i] = tout.trans[i];
    end
    out_w[io_status_pkg::BIT_AUX] = tout.aux;
    out_w[io_status_pkg::BIT_ALM] = tout.alm;
  end

  logic [15:0] link_w;
  always_comb begin
    // link bits taken as sent, active high, never inverted
    link_w = pack_in(link_in_i);
    link_w[io_status_pkg::BIT_LFWD] = link_forward_command_i;
    link_w[io_status_pkg::BIT_LBWD] = link_backward_command_i;
    link_w[io_status_pkg::BIT_LRST] = link_reset_command_i;
  end

  // words refreshed every cycle, terminal words three cycles behind the pins, link word one cycle behind its inputs
  always_ff @(posedge ref_clk_i or negedge rst_b_q) begin
    if (!rst_b_q) begin
      terminal_input_word_o <= io_status_pkg::WORD_RST;
      terminal_output_word_o <= io_status_pkg::WORD_RST;
      link_input_word_o <= io_status_pkg::WORD_RST;
    end else begin
      terminal_input_word_o <= pack_in(tin);
      terminal_output_word_o <= out_w;
      link_input_word_o <= link_w;
    end
  end

  // segment or hex presentation for link commands
  always_ff @(posedge ref_clk_i or negedge rst_b_q) begin
    if (!rst_b_q) begin
      link_hex_view_o <= 1'b0;
      link_segments_o <= '0;
    end else begin
      link_hex_view_o <= link_command_word_setting_i;
      // segments blank in hex view so only one form is shown
      link_segments_o <= link_command_word_setting_i ? 10'h000 :
        {link_w[15:13], link_w[6:0]};
    end
  end

  // ---------------------------------------------------------------
  // hour counters
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_b_q) begin
    if (!rst_b_q) begin
      power_on_hours_o <= io_status_pkg::WORD_RST;
    end else if (hour_tick_i) begin
      power_on_hours_o <= power_on_hours_o + 16'h0001; // wraps
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_q) begin
    if (!rst_b_q) begin
      motor_run_hours_o <= io_status_pkg::WORD_RST;
    end else if (hour_tick_i && motor_running_i) begin
      motor_run_hours_o <= motor_run_hours_o + 16'h0001;
    end
  end

  // weighted hours kept with fraction bits; coefficient 8'h100 scale
  logic [23:0] cap_acc_q;
  logic [24:0] cap_sum;
  assign cap_sum = {1'b0, cap_acc_q} + {17'h00000, env_coeff_i};
  always_ff @(posedge ref_clk_i or negedge rst_b_q) begin
    if (!rst_b_q) begin
      cap_acc_q <= '0;
    end else if (hour_tick_i && cap_under_voltage_i) begin
      // saturate instead of wrapping: life figure must never look young
      cap_acc_q <= cap_sum[24] ? 24'hffffff : cap_sum[23:0];
    end
  end
  always_ff @(posedge ref_clk_i or negedge rst_b_q) begin
    if (!rst_b_q) begin
      board_electrolytic_hours_o <= io_status_pkg::WORD_RST;
    end else begin
      board_electrolytic_hours_o <=
        cap_acc_q[io_status_pkg::CAP_SHIFT +: 16];
    end
  end

  // ---------------------------------------------------------------
  // hourly peaks
  // ---------------------------------------------------------------
  io_status_pkg::peaks_t run_q;
  always_ff @(posedge ref_clk_i or negedge rst_b_q) begin
    if (!rst_b_q) begin
      run_q <= '0;
      hourly_peaks_o <= '0;
    end else if (hour_tick_i) begin
      // publish the finished hour, this sample included, and restart from zero
      hourly_peaks_o.int_temp <= (sample_i.int_temp > run_q.int_temp) ?
        sample_i.int_temp : run_q.int_temp;
      hourly_peaks_o.hs_temp <= (sample_i.hs_temp > run_q.hs_temp) ?
        sample_i.hs_temp : run_q.hs_temp;
      hourly_peaks_o.rms_cur <= (sample_i.rms_cur > run_q.rms_cur) ?
        sample_i.rms_cur : run_q.rms_cur;
      run_q <= '0;
    end else begin
      if (sample_i.int_temp > run_q.int_temp)
        run_q.int_temp <= sample_i.int_temp;
      if (sample_i.hs_temp > run_q.hs_temp)
        run_q.hs_temp <= sample_i.hs_temp;
      if (sample_i.rms_cur > run_q.rms_cur)
        run_q.rms_cur <= sample_i.rms_cur;
    end
  end

  // ---------------------------------------------------------------
  // capacitor health
  // ---------------------------------------------------------------
  // coarse divide: saturates at 8'hff, zero when shipment value unknown
  logic [22:0] cap_scaled;
  logic [22:0] cap_pct;
  assign cap_scaled = {7'h00, bus_cap_now_i} * 23'h000064;
  assign cap_pct = (bus_cap_ship_i == 16'h0000) ? 23'h000000 :
    cap_scaled / {7'h00, bus_cap_ship_i};
  always_ff @(posedge ref_clk_i or negedge rst_b_q) begin
    if (!rst_b_q) begin
      bus_cond_health_pct_o <= io_status_pkg::PCT_FULL;
    end else begin
      bus_cond_health_pct_o <= (cap_pct > 23'h0000ff) ? 8'hff :
        cap_pct[7:0];
    end
  end

  // ---------------------------------------------------------------
  // keypad mode and i/o check pages
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_b_q) begin
    if (!rst_b_q) begin
      kp_mode_o <= io_status_pkg::MODE_RUN;
      io_page_o <= 3'h0;
    end else begin
      case (kp_mode_o)
        io_status_pkg::MODE_RUN: begin
          if (key_prog_i) kp_mode_o <= io_status_pkg::MODE_MENU;
        end
        io_status_pkg::MODE_MENU: begin
          if (key_reset_i) kp_mode_o <= io_status_pkg::MODE_RUN;
          else if (key_prog_i) begin
            kp_mode_o <= io_status_pkg::MODE_IOCHK;
            io_page_o <= 3'h0;
          end
        end
        io_status_pkg::MODE_IOCHK: begin
          if (key_reset_i) begin
            kp_mode_o <= io_status_pkg::MODE_MENU;
          end else if (key_up_i) begin
            io_page_o <= (io_page_o == io_status_pkg::PAGE_LAST) ? 3'h0 :
              io_page_o + 3'h1;
          end else if (key_down_i) begin
            io_page_o <= (io_page_o == 3'h0) ? io_status_pkg::PAGE_LAST :
              io_page_o - 3'h1;
          end
        end
        default: kp_mode_o <= io_status_pkg::MODE_RUN;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_in_fwd_bit: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_q)
    $past(rst_b_q, 3) |-> terminal_input_word_o[0] == $past(term_in_i.forward_run_input, 3))
    else $error("forward bit wrong");
  a_in_unmapped: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_q)
    terminal_input_word_o[15:7] == 9'h000)
    else $error("input unmapped bits set");
  a_out_unmapped: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_q)
    (terminal_output_word_o & 16'hfee8) == 16'h0000)
    else $error("output unmapped bits set");
  a_alarm_bit: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_q)
    $past(rst_b_q, 3) |->
    terminal_output_word_o[8] == $past(term_out_i.alm, 3))
    else $error("alarm bit wrong");
  a_link_fwd: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_q)
    $past(rst_b_q) |->
    link_input_word_o[13] == $past(link_forward_command_i))
    else $error("link forward bit wrong");
  a_hours_wrap: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_q)
    hour_tick_i && power_on_hours_o == 16'hffff |=> power_on_hours_o == 16'h0)
    else $error("power hours did not wrap");
  a_motor_hold: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_q)
    !(hour_tick_i && motor_running_i) |=> $stable(motor_run_hours_o))
    else $error("motor hours moved");
  a_cap_sat: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_q)
    cap_acc_q == 24'hffffff |=> cap_acc_q == 24'hffffff)
    else $error("capacitor hours wrapped");
  a_peak_clear: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_q)
    hour_tick_i |=> run_q == '0)
    else $error("peak not cleared");
  a_page_range: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_q)
    io_page_o <= io_status_pkg::PAGE_LAST)
    else $error("page out of range");
  c_hour_tick: cover property (@(posedge ref_clk_i) disable iff (!rst_b_q)
    hour_tick_i && motor_running_i);
  c_io_check: cover property (@(posedge ref_clk_i) disable iff (!rst_b_q)
    kp_mode_o == io_status_pkg::MODE_IOCHK && io_page_o == 3'h5);
  c_hex_view: cover property (@(posedge ref_clk_i) disable iff (!rst_b_q)
    link_hex_view_o && link_input_word_o[14]);
endmodule // io_status_word_and_maintenance_counters

// [hdl/io_status_pkg.sv]
// constants and carrier types for the i/o status and maintenance block
package io_status_pkg;
  // ---------------------------------------------------------------
  // word layout
  // ---------------------------------------------------------------
  localparam int WORD_W = 16;
  localparam int BIT_FWD = 0;
  localparam int BIT_BWD = 1;
  localparam int BIT_GEN0 = 2;
  localparam int GEN_N = 5;
  localparam int BIT_TR0 = 0;
  localparam int TR_N = 3;
  localparam int BIT_AUX = 4;
  localparam int BIT_ALM = 8;
  localparam int BIT_LFWD = 13;
  localparam int BIT_LBWD = 14;
  localparam int BIT_LRST = 15;
  localparam logic [15:0] HOURS_MAX = 16'hffff;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [7:0] PEAK_RST = 8'h00;
  localparam int CAP_SHIFT = 8; // weighted accum fraction bits
  localparam logic [7:0] PCT_FULL = 8'h64;
  localparam logic [2:0] PAGE_LAST = 3'h5;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_RUN = 2'b00,
    MODE_MENU = 2'b01,
    MODE_IOCHK = 2'b10
  } kp_mode_t;
  typedef struct packed {
    logic forward_run_input;
    logic bwd;
    logic [4:0] gen;
  } term_in_t;
  typedef struct packed {
    logic [2:0] trans;
    logic aux;
    logic alm;
  } term_out_t;
  typedef struct packed {
    logic [7:0] int_temp;
    logic [7:0] hs_temp;
    logic [7:0] rms_cur;
  } peaks_t;
endpackage

// [testbench/keypad_terminal_model.sv]
// far side model: terminal pins and the debounced keypad
module keypad_terminal_model (
  input wire logic ref_clk_i,
  output io_status_pkg::term_in_t term_in_o,
  output io_status_pkg::term_out_t term_out_o,
  output logic [3:0] keys_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // ---------------------------------------------------------------
  // pins idle inactive, keys released
  // ---------------------------------------------------------------
  initial begin
    term_in_o = '0;
    term_out_o = '0;
    keys_o = 4'h0;
  end
  // one key pulse of one cycle; keys never overlap
  task automatic press(input int k);
    @(posedge ref_clk_i) #1;
    keys_o[k] = 1'b1;
    @(posedge ref_clk_i) #1;
    keys_o = 4'h0;
  endtask
  // pins move together, just after an edge
  task automatic pins(input io_status_pkg::term_in_t i,
                      input io_status_pkg::term_out_t o);
    @(posedge ref_clk_i) #1;
    term_in_o = i;
    term_out_o = o;
  endtask
endmodule // keypad_terminal_model

// [testbench/tb_top.sv]
// self-checking bench for the status word and maintenance block
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  io_status_pkg::term_in_t ti, li;
  io_status_pkg::term_out_t to;
  io_status_pkg::peaks_t smp, pk_o;
  io_status_pkg::kp_mode_t mode_o;
  logic [3:0] keys;
  logic lf = 0, lb = 0, lr = 0, lset = 0, mrun = 0, cuv = 0, tick = 0;
  logic [7:0] env = 8'h00, pct_o;
  logic [15:0] cnow = 16'h0000, cship = 16'h0000;
  logic [15:0] wi_o, wo_o, wl_o, poh_o, mrh_o, cap_o;
  logic [9:0] seg_o;
  logic hex_o;
  logic [2:0] page_o;
  int seed = 20946, miscompares = 0, n_tests = 0, cyc = 0;
  int poh = 0, mrh = 0, cacc = 0, e;
  logic [23:0] run = '0, pk = '0;
  logic [15:0] w;
  keypad_terminal_model u_keypad_terminal_model (.ref_clk_i(ref_clk_i),
    .term_in_o(ti), .term_out_o(to), .keys_o(keys));
  io_status_word_and_maintenance_counters
    u_io_status_word_and_maintenance_counters (
    .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .term_in_i(ti),
    .term_out_i(to), .link_in_i(li), .link_forward_command_i(lf),
    .link_backward_command_i(lb), .link_reset_command_i(lr),
    .link_command_word_setting_i(lset), .motor_running_i(mrun),
    .cap_under_voltage_i(cuv), .env_coeff_i(env), .sample_i(smp),
    .bus_cap_now_i(cnow), .bus_cap_ship_i(cship), .hour_tick_i(tick),
    .key_up_i(keys[0]), .key_down_i(keys[1]), .key_prog_i(keys[2]),
    .key_reset_i(keys[3]), .terminal_input_word_o(wi_o),
    .terminal_output_word_o(wo_o), .link_input_word_o(wl_o),
    .link_segments_o(seg_o), .link_hex_view_o(hex_o),
    .power_on_hours_o(poh_o), .motor_run_hours_o(mrh_o),
    .board_electrolytic_hours_o(cap_o), .hourly_peaks_o(pk_o),
    .bus_cond_health_pct_o(pct_o), .kp_mode_o(mode_o),
    .io_page_o(page_o));
  // ---------------------------------------------------------------
  // clock, timeout and checking helpers
  // ---------------------------------------------------------------
  initial forever #5 ref_clk_i = ~ref_clk_i;
  // the run needs about 66200 cycles, mostly the tick burst; ample slack
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 80000) begin
      miscompares++;
      final_report();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_tests++;
    if (g !== x) begin
      miscompares++;
      $display("Error %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic edges(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  // key press then expected mode and page
  task automatic key(input int k, input int m, input int p);
    u_keypad_terminal_model.press(k);
    chk(mode_o, m);
    if (m == 2) chk(page_o, p);
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    li = '0;
    smp = '0;
    edges(10);
    chk({wi_o, wo_o}, 32'h0);
    chk({pct_o, mode_o}, {8'h64, 2'b00});
    edges(10);
    rst_b_i = 1'b1;
    edges(4);
    // terminal and output words, random pins
    for (int n = 0; n < 40; n++) begin
      u_keypad_terminal_model.pins(7'($random(seed)), 5'($random(seed)));
      edges(3);
      chk(wi_o, {9'h0, ti.gen, ti.bwd, ti.forward_run_input});
      chk(wo_o, {7'h0, to.alm, 3'h0, to.aux, 1'b0, to.trans});
    end
    // link word, segment view and hex view
    for (int n = 0; n < 24; n++) begin
      li = 7'($random(seed));
      {lr, lb, lf, lset} = 4'($random(seed));
      edges(2);
      w = {lr, lb, lf, 6'h0, li.gen, li.bwd, li.forward_run_input};
      chk(wl_o, w);
      chk({hex_o, seg_o}, lset ? 11'h400 : {1'b0, w[15:13], w[6:0]});
    end
    // capacitor health percentage, ship of zero first
    for (int n = 0; n < 16; n++) begin
      cship = (n == 0) ? 16'h0 : 16'($random(seed));
      cnow = 16'($random(seed));
      edges(2);
      e = (cship == 0) ? 0 : (int'(cnow) * 100) / int'(cship);
      chk(pct_o, (e > 255) ? 255 : e);
    end
    // hour ticks: counters, gating and peaks
    for (int h = 0; h < 8; h++) begin
      for (int c = 0; c < 5; c++) begin
        smp = 24'($random(seed));
        tick = (c == 4);
        if (tick) begin
          {mrun, cuv} = 2'($random(seed));
          env = 8'($random(seed));
        end
        for (int b = 0; b < 24; b += 8)
          if (smp[b+:8] > run[b+:8]) run[b+:8] = smp[b+:8];
        edges(1);
      end
      pk = run;
      run = '0;
      poh++;
      if (mrun) mrh++;
      if (cuv) cacc += env;
      tick = 0;
      smp = '0;
      edges(3);
      chk(poh_o, poh);
      chk(mrh_o, mrh);
      chk(cap_o, cacc >> 8);
      chk(pk_o, pk);
    end
    // back-to-back ticks: both hour counters wrap, capacitor saturates
    smp = '0;
    {mrun, cuv} = 2'b11;
    env = 8'hff;
    tick = 1'b1;
    for (int n = 0; n < 65800; n++) begin
      poh = (poh + 1) % 65536;
      mrh = (mrh + 1) % 65536;
      cacc = (cacc + 255 > 16777215) ? 16777215 : cacc + 255;
      edges(1);
    end
    tick = 1'b0;
    edges(3);
    chk(poh_o, poh);
    chk(mrh_o, mrh);
    chk(cap_o, cacc >> 8);
    chk(pk_o, 24'h000000);
    // keypad: up 0, down 1, prog 2, reset 3
    key(0, 0, 0);
    key(2, 1, 0);
    key(2, 2, 0);
    key(1, 2, 5);
    key(0, 2, 0);
    for (int p = 1; p < 6; p++) key(0, 2, p);
    key(3, 1, 0);
    key(3, 0, 0);
    final_report();
  end
endmodule // tb_top
